// File: rtl/gpio_gh_pkg.sv
// Package for the two 8-bit general-purpose ports G and H.
// Assumes a single 40 MHz clock and a plain strobe-based register port.
package gpio_gh_pkg;

  localparam int PIN_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int OFFS_W = 6;
  // Address bit that selects port H over port G.
  localparam int PORT_SEL_BIT = 6;

  // Register offsets within one port block.
  localparam logic [OFFS_W-1:0] OFFS_DATA = 6'h00;
  localparam logic [OFFS_W-1:0] OFFS_OUTPUT_ENABLE = 6'h04;
  localparam logic [OFFS_W-1:0] OFFS_FUNCTION = 6'h08;
  localparam logic [OFFS_W-1:0] OFFS_RESERVED = 6'h10;
  localparam logic [OFFS_W-1:0] OFFS_OPEN_DRAIN = 6'h28;
  localparam logic [OFFS_W-1:0] OFFS_PULLUP = 6'h2C;
  localparam logic [OFFS_W-1:0] OFFS_INPUT_ENABLE = 6'h38;

  // Reset values of the pin control registers.
  localparam logic [PIN_W-1:0] PIN_RST = 8'h00;
  localparam logic [PIN_W-1:0] PIN_ALL = 8'hFF;
  localparam logic [PIN_W-1:0] PH_PULLUP_RST = 8'h01;
  localparam logic [PIN_W-1:0] STRAP_MASK = 8'h01;
  localparam logic [DATA_W-PIN_W-1:0] RD_UPPER_ZERO = 24'h00_0000;

  localparam int STRAP_BIT = 0;
  localparam int EXTERNAL_INTERRUPT_4_BIT = 3;
  // Clock edges the strap waits for its synchroniser to fill.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [1:0] SETTLE_STEP = 2'h1;

  typedef enum logic [1:0] {
    BOOT_WAIT,
    BOOT_FLASH,
    BOOT_ROM
  } boot_state_t;

  typedef struct packed {
    logic [PIN_W-1:0] pg_data;
    logic [PIN_W-1:0] pg_oe;
    logic [PIN_W-1:0] pg_fs;
    logic [PIN_W-1:0] pg_od;
    logic [PIN_W-1:0] pg_pu;
    logic [PIN_W-1:0] pg_ie;
    logic [PIN_W-1:0] ph_data;
    logic [PIN_W-1:0] ph_oe;
    logic [PIN_W-1:0] ph_fs;
    logic [PIN_W-1:0] ph_pu;
    logic [PIN_W-1:0] ph_ie;
    logic [PIN_W-1:0] pg_s1;
    logic [PIN_W-1:0] pg_s2;
    logic [PIN_W-1:0] ph_s1;
    logic [PIN_W-1:0] ph_s2;
    logic [PIN_W-1:0] pg_out;
    logic [PIN_W-1:0] pg_oe_n;
    logic [PIN_W-1:0] pg_pin_pu;
    logic [PIN_W-1:0] pg_pin_ie;
    logic [PIN_W-1:0] ph_out;
    logic [PIN_W-1:0] ph_oe_n;
    logic [PIN_W-1:0] ph_pin_pu;
    logic [PIN_W-1:0] ph_pin_ie;
    logic external_interrupt_4;
    logic [DATA_W-1:0] rdata;
    boot_state_t boot;
    logic [1:0] settle;
  } state_t;

  localparam state_t STATE_RST = '{
    pg_data: PIN_RST, pg_oe: PIN_RST, pg_fs: PIN_RST, pg_od: PIN_RST,
    pg_pu: PIN_RST, pg_ie: PIN_RST, ph_data: PIN_RST, ph_oe: PIN_RST,
    ph_fs: PIN_RST, ph_pu: PH_PULLUP_RST, ph_ie: PIN_RST,
    pg_s1: PIN_RST, pg_s2: PIN_RST, ph_s1: PIN_RST, ph_s2: PIN_RST,
    pg_out: PIN_RST, pg_oe_n: PIN_ALL, pg_pin_pu: PIN_RST,
    pg_pin_ie: PIN_RST, ph_out: PIN_RST, ph_oe_n: PIN_ALL,
    ph_pin_pu: PH_PULLUP_RST, ph_pin_ie: STRAP_MASK, external_interrupt_4: 1'b0,
    rdata: 32'h0000_0000, boot: BOOT_WAIT, settle: 2'h0
  };

endpackage

// File: rtl/gpio_ports_g_h.sv
// Two 8-bit general-purpose ports G and H with per-pin control registers.
// Assumes one 40 MHz clock, pins sampled from outside its domain, and a
// register master that never issues read and write strobes together.
`timescale 1ns/1ps

module gpio_ports_g_h (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [gpio_gh_pkg::ADDR_W-1:0] i_addr,
  input wire logic [gpio_gh_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [gpio_gh_pkg::DATA_W-1:0] o_rdata,
  input wire logic [gpio_gh_pkg::PIN_W-1:0] i_pg_pin,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_pg_out,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_pg_oe_n,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_pg_pullup,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_pg_in_en,
  input wire logic [gpio_gh_pkg::PIN_W-1:0] i_pg_alt_out,
  input wire logic [gpio_gh_pkg::PIN_W-1:0] i_pg_alt_drive,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_pg_alt_in,
  output logic o_external_interrupt_4,
  input wire logic [gpio_gh_pkg::PIN_W-1:0] i_ph_pin,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_ph_out,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_ph_oe_n,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_ph_pullup,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_ph_in_en,
  output logic [gpio_gh_pkg::PIN_W-1:0] o_ph_timer_in,
  output logic o_boot_valid,
  output logic o_boot_from_flash,
  output logic o_boot_from_rom
);

  gpio_gh_pkg::state_t s_r;
  gpio_gh_pkg::state_t s_nxt;
  logic sel_h;
  logic addr_hi;
  logic [gpio_gh_pkg::OFFS_W-1:0] offs;
  logic wr_g;
  logic wr_h;
  logic [gpio_gh_pkg::PIN_W-1:0] rd_byte;
  logic [gpio_gh_pkg::PIN_W-1:0] pg_drive;
  logic [gpio_gh_pkg::PIN_W-1:0] pg_val;
  logic [gpio_gh_pkg::PIN_W-1:0] ph_drive;
  logic [gpio_gh_pkg::PIN_W-1:0] strap_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  assign sel_h = i_addr[gpio_gh_pkg::PORT_SEL_BIT];
  assign addr_hi = |i_addr[gpio_gh_pkg::ADDR_W-1:gpio_gh_pkg::PORT_SEL_BIT+1];
  assign offs = i_addr[gpio_gh_pkg::OFFS_W-1:0];
  assign wr_g = i_wr && !addr_hi && !sel_h;
  assign wr_h = i_wr && !addr_hi && sel_h;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    s_nxt = s_r;
    rd_byte = gpio_gh_pkg::PIN_RST;
    // Bits with no register behind them always read as zero.
    s_nxt.rdata = '0;
    // Port G writes; unmapped and reserved offsets are ignored.
    if (wr_g) begin
      case (offs)
        gpio_gh_pkg::OFFS_DATA: begin
          s_nxt.pg_data = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_OUTPUT_ENABLE: begin
          s_nxt.pg_oe = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_FUNCTION: begin
          s_nxt.pg_fs = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_OPEN_DRAIN: begin
          s_nxt.pg_od = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_PULLUP: begin
          s_nxt.pg_pu = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_INPUT_ENABLE: begin
          s_nxt.pg_ie = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Port H writes; it has no open-drain register.
    if (wr_h) begin
      case (offs)
        gpio_gh_pkg::OFFS_DATA: begin
          s_nxt.ph_data = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_OUTPUT_ENABLE: begin
          s_nxt.ph_oe = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_FUNCTION: begin
          s_nxt.ph_fs = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_PULLUP: begin
          s_nxt.ph_pu = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        gpio_gh_pkg::OFFS_INPUT_ENABLE: begin
          s_nxt.ph_ie = i_wdata[gpio_gh_pkg::PIN_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Reads: a pin with its output-enable bit set returns its latch, otherwise the gated pin.
    if (i_rd && !addr_hi) begin
      case (offs)
        gpio_gh_pkg::OFFS_DATA: begin
          if (sel_h) begin
            rd_byte = (s_r.ph_oe & s_r.ph_data)
              | (~s_r.ph_oe & s_r.ph_s2 & s_r.ph_ie);
          end else begin
            rd_byte = (s_r.pg_oe & s_r.pg_data)
              | (~s_r.pg_oe & s_r.pg_s2 & s_r.pg_ie);
          end
        end
        gpio_gh_pkg::OFFS_OUTPUT_ENABLE: begin
          rd_byte = sel_h ? s_r.ph_oe : s_r.pg_oe;
        end
        gpio_gh_pkg::OFFS_FUNCTION: begin
          rd_byte = sel_h ? s_r.ph_fs : s_r.pg_fs;
        end
        gpio_gh_pkg::OFFS_OPEN_DRAIN: begin
          rd_byte = sel_h ? gpio_gh_pkg::PIN_RST : s_r.pg_od;
        end
        gpio_gh_pkg::OFFS_PULLUP: begin
          rd_byte = sel_h ? s_r.ph_pu : s_r.pg_pu;
        end
        gpio_gh_pkg::OFFS_INPUT_ENABLE: begin
          rd_byte = sel_h ? s_r.ph_ie : s_r.pg_ie;
        end
        default: begin
          rd_byte = gpio_gh_pkg::PIN_RST;
        end
      endcase
      s_nxt.rdata = {gpio_gh_pkg::RD_UPPER_ZERO, rd_byte};
    end
    // Pin synchronisers, two flops each.
    s_nxt.pg_s1 = i_pg_pin;
    s_nxt.pg_s2 = s_r.pg_s1;
    s_nxt.ph_s1 = i_ph_pin;
    s_nxt.ph_s2 = s_r.ph_s1;
    // Boot strap capture once the synchroniser holds a settled level.
    case (s_r.boot)
      gpio_gh_pkg::BOOT_WAIT: begin
        if (s_r.settle == gpio_gh_pkg::STRAP_SETTLE) begin
          if (s_r.ph_s2[gpio_gh_pkg::STRAP_BIT]) begin
            s_nxt.boot = gpio_gh_pkg::BOOT_FLASH;
          end else begin
            s_nxt.boot = gpio_gh_pkg::BOOT_ROM;
          end
        end else begin
          s_nxt.settle = s_r.settle + gpio_gh_pkg::SETTLE_STEP;
        end
      end
      gpio_gh_pkg::BOOT_FLASH, gpio_gh_pkg::BOOT_ROM: begin
      end
      default: begin
        s_nxt.boot = gpio_gh_pkg::BOOT_WAIT;
      end
    endcase
    // Port G drive: the peripheral takes over when selected.
    pg_drive = (s_r.pg_fs & i_pg_alt_drive)
      | (~s_r.pg_fs & s_r.pg_oe);
    pg_val = (s_r.pg_fs & i_pg_alt_out) | (~s_r.pg_fs & s_r.pg_data);
    // Open-drain bits only ever pull low.
    s_nxt.pg_out = pg_val & ~s_r.pg_od;
    s_nxt.pg_oe_n = ~(pg_drive & ~(s_r.pg_od & pg_val));
    s_nxt.pg_pin_pu = s_r.pg_pu;
    s_nxt.pg_pin_ie = s_r.pg_ie;
    s_nxt.external_interrupt_4 = s_r.pg_s2[gpio_gh_pkg::EXTERNAL_INTERRUPT_4_BIT]
      & s_r.pg_ie[gpio_gh_pkg::EXTERNAL_INTERRUPT_4_BIT];
    // Port H: a timer-input pin is never driven.
    ph_drive = s_r.ph_oe & ~s_r.ph_fs;
    s_nxt.ph_out = s_r.ph_data;
    s_nxt.ph_oe_n = ~ph_drive;
    // Until the strap is taken, its input buffer and pull-up stay on.
    strap_hold = (s_r.boot == gpio_gh_pkg::BOOT_WAIT)
      ? gpio_gh_pkg::STRAP_MASK : gpio_gh_pkg::PIN_RST;
    s_nxt.ph_pin_pu = s_r.ph_pu | strap_hold;
    s_nxt.ph_pin_ie = s_r.ph_ie | strap_hold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= gpio_gh_pkg::STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign o_rdata = s_r.rdata;
  assign o_pg_out = s_r.pg_out;
  assign o_pg_oe_n = s_r.pg_oe_n;
  assign o_pg_pullup = s_r.pg_pin_pu;
  assign o_pg_in_en = s_r.pg_pin_ie;
  assign o_pg_alt_in = s_r.pg_s2 & s_r.pg_ie & s_r.pg_fs;
  assign o_external_interrupt_4 = s_r.external_interrupt_4;
  assign o_ph_out = s_r.ph_out;
  assign o_ph_oe_n = s_r.ph_oe_n;
  assign o_ph_pullup = s_r.ph_pin_pu;
  assign o_ph_in_en = s_r.ph_pin_ie;
  assign o_ph_timer_in = s_r.ph_s2 & s_r.ph_ie & s_r.ph_fs;
  assign o_boot_valid = (s_r.boot != gpio_gh_pkg::BOOT_WAIT);
  assign o_boot_from_flash = (s_r.boot == gpio_gh_pkg::BOOT_FLASH);
  assign o_boot_from_rom = (s_r.boot == gpio_gh_pkg::BOOT_ROM);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  read_upper_zero_a: assert property (
    i_rd |=> (o_rdata[gpio_gh_pkg::DATA_W-1:gpio_gh_pkg::PIN_W] == '0))
    else $error("upper read data bits not zero");

  data_readback_a: assert property (
    (wr_g && offs == gpio_gh_pkg::OFFS_DATA
      && s_r.pg_oe == gpio_gh_pkg::PIN_ALL)
    ##1 !i_wr
    ##1 (i_rd && !addr_hi && !sel_h && offs == gpio_gh_pkg::OFFS_DATA)
    |=> (o_rdata[gpio_gh_pkg::PIN_W-1:0] == $past(i_wdata[7:0], 3)))
    else $error("port G data did not read back");

  float_undriven_a: assert property (
    1'b1 |=> ((o_pg_oe_n | $past(s_r.pg_oe | s_r.pg_fs))
      == gpio_gh_pkg::PIN_ALL))
    else $error("port G pin driven without enable");

  open_drain_low_a: assert property (
    1'b1 |=> ((o_pg_out & $past(s_r.pg_od)) == gpio_gh_pkg::PIN_RST))
    else $error("open-drain pin driven high");

  alt_drive_a: assert property (
    (s_r.pg_fs[7] && i_pg_alt_drive[7] && !s_r.pg_od[7])
    |=> (!o_pg_oe_n[7] && o_pg_out[7] == $past(i_pg_alt_out[7])))
    else $error("timer output not routed to pin");

  pullup_follow_a: assert property (
    ##1 (o_pg_pullup == $past(s_r.pg_pu)))
    else $error("port G pull-up does not follow register");

  input_gate_a: assert property (
    (o_pg_alt_in & ~s_r.pg_ie) == gpio_gh_pkg::PIN_RST)
    else $error("input passed with buffer disabled");

  external_interrupt_4_follow_a: assert property (
    ##1 (o_external_interrupt_4 == $past(s_r.pg_s2[3] & s_r.pg_ie[3])))
    else $error("interrupt 4 does not follow its pin");

  strap_hold_a: assert property (
    (s_r.boot == gpio_gh_pkg::BOOT_WAIT) |-> (o_ph_in_en[0] && o_ph_pullup[0]))
    else $error("strap input or pull-up off before capture");

  boot_choice_a: assert property (
    $rose(o_boot_valid) |-> (o_boot_from_flash == $past(s_r.ph_s2[0])
      && o_boot_from_rom != o_boot_from_flash))
    else $error("boot mode does not match strap level");

  boot_stable_a: assert property (
    o_boot_valid |=> (o_boot_valid && $stable(o_boot_from_flash)))
    else $error("boot mode changed after capture");

  h_pullup_map_a: assert property (
    (wr_h && offs == gpio_gh_pkg::OFFS_PULLUP)
    |=> ##1 (o_ph_pullup[7:1] == $past(i_wdata[7:1], 2)))
    else $error("port H pull-up write misplaced");

  h_timer_float_a: assert property (
    s_r.ph_fs[0] |=> o_ph_oe_n[0])
    else $error("timer input pin is driven");

  // The first edge after release still shows the reset pad controls.
  reset_state_a: assert property (
    $rose(i_reset_n) |-> (o_pg_oe_n == gpio_gh_pkg::PIN_ALL
      && o_ph_oe_n == gpio_gh_pkg::PIN_ALL
      && o_pg_pullup == gpio_gh_pkg::PIN_RST
      && o_pg_in_en == gpio_gh_pkg::PIN_RST
      && o_ph_pullup == gpio_gh_pkg::PH_PULLUP_RST))
    else $error("pin controls not at reset values after reset");

  boot_timing_a: assert property (
    $rose(i_reset_n) |-> !o_boot_valid ##2 !o_boot_valid ##1 o_boot_valid)
    else $error("boot mode not taken three edges after reset");

  refused_write_a: assert property (
    (i_wr && addr_hi) |=> ($stable(s_r.pg_oe) && $stable(s_r.ph_oe)
      && $stable(s_r.pg_data) && $stable(s_r.ph_data)))
    else $error("write outside the port block changed a register");

  h_data_map_a: assert property (
    (wr_h && offs == gpio_gh_pkg::OFFS_DATA)
    |=> ##1 (o_ph_out == $past(i_wdata[gpio_gh_pkg::PIN_W-1:0], 2)))
    else $error("port H data write misplaced");

  g_input_follow_a: assert property (
    ##1 (o_pg_in_en == $past(s_r.pg_ie)))
    else $error("port G input enable does not follow register");

  strap_release_a: assert property (
    o_boot_valid |=> (o_ph_pullup == $past(s_r.ph_pu)
      && o_ph_in_en == $past(s_r.ph_ie)))
    else $error("strap override held after boot mode taken");

  boot_flash_c: cover property ($rose(o_boot_from_flash));
  boot_rom_c: cover property ($rose(o_boot_from_rom));
  alt_drive_c: cover property (s_r.pg_fs[7] && i_pg_alt_drive[7]);
  external_interrupt_4_rise_c: cover property ($rose(o_external_interrupt_4));
  refused_write_c: cover property (i_wr && addr_hi);

endmodule

// File: tb/pad_board_model.sv
// Board side of one 8-pin port: pad drivers, pull-ups and outside drivers.
// Assumes the pad controls come from the port block on the system clock.
`timescale 1ns/1ps
module pad_board_model (
  input wire logic i_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_pin
);
  logic [7:0] last_r = 8'h00;

  // A pin that nobody drives or pulls shows the inverse of its last level
  // each cycle, so a floating pin never reads as a settled value.
  assign o_pin = (~i_oe_n & i_out) | (i_oe_n & i_ext_en & i_ext_val) |
                 (i_oe_n & ~i_ext_en & (i_pullup | ~last_r));

  always @(posedge i_clk) begin
    last_r <= o_pin;
  end
endmodule

// File: tb/gpio_ports_g_h_test.sv
// Self-checking bench for the two 8-pin ports G and H.
// Assumes the register port of the design and one board model per port.
`timescale 1ns/1ps
module gpio_ports_g_h_test;
  logic i_clk = 1'b0;
  logic i_reset_n, i_wr, i_rd, o_external_interrupt_4;
  logic o_boot_valid, o_boot_from_flash, o_boot_from_rom;
  logic [7:0] i_addr, i_pg_pin, o_pg_out, o_pg_oe_n, o_pg_pullup;
  logic [7:0] o_pg_in_en, i_pg_alt_out, i_pg_alt_drive, o_pg_alt_in;
  logic [7:0] i_ph_pin, o_ph_out, o_ph_oe_n, o_ph_pullup, o_ph_in_en;
  logic [7:0] o_ph_timer_in, strap_en, en, pin;
  logic [15:0] e;
  logic [31:0] i_wdata, o_rdata;
  logic [7:0] regs [11] = '{8'h00, 8'h04, 8'h08, 8'h28, 8'h2C, 8'h38,
                            8'h40, 8'h44, 8'h48, 8'h6C, 8'h78};
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  always #12.5 i_clk = ~i_clk;

  gpio_ports_g_h uut (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_pg_pin, .o_pg_out, .o_pg_oe_n, .o_pg_pullup, .o_pg_in_en,
    .i_pg_alt_out, .i_pg_alt_drive, .o_pg_alt_in, .o_external_interrupt_4,
    .i_ph_pin, .o_ph_out, .o_ph_oe_n, .o_ph_pullup, .o_ph_in_en,
    .o_ph_timer_in, .o_boot_valid, .o_boot_from_flash, .o_boot_from_rom);

  pad_board_model g_pads (.i_clk(i_clk), .i_out(o_pg_out),
    .i_oe_n(o_pg_oe_n), .i_pullup(o_pg_pullup), .i_ext_val(8'h00),
    .i_ext_en(8'h00), .o_pin(i_pg_pin));
  pad_board_model h_pads (.i_clk(i_clk), .i_out(o_ph_out),
    .i_oe_n(o_ph_oe_n), .i_pullup(o_ph_pullup), .i_ext_val(8'h00),
    .i_ext_en(strap_en), .o_pin(i_ph_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check("rdata", o_rdata, exp);
  endtask

  task automatic wait6();
    repeat (6) @(posedge i_clk);
    #1;
  endtask

  task automatic do_reset(input logic flash);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    #1;
    check("rst_ph_pins", {o_ph_in_en, o_ph_pullup}, 16'h0101);
    check("rst_pads", {o_pg_oe_n, o_ph_oe_n, o_pg_pullup, o_pg_in_en},
          32'hFFFF_0000);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    wait6();
    check("boot", {o_boot_valid, o_boot_from_flash, o_boot_from_rom},
          {1'b1, flash, ~flash});
    for (int i = 0; i < 11; i++) begin
      rdchk(regs[i], (regs[i] == 8'h6C) ? 32'h1 : 32'h0);
    end
  endtask

  function automatic logic [15:0] g_drive(input logic [7:0] d, oe, fs, od,
                                          ao, ad);
    logic [7:0] v, n;
    v = (fs & ao) | (~fs & d);
    n = ((fs & ad) | (~fs & oe)) & ~(od & v);
    return {~n, v & ~od};
  endfunction

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_pg_alt_out = 8'h00;
    i_pg_alt_drive = 8'h00;
    strap_en = 8'h01;
    do_reset(1'b0);
    strap_en <= 8'h00;
    for (int i = 1; i < 11; i++) begin
      if (i != 6) wr(regs[i], {24'hDEAD_BE, 8'hA5 ^ 8'(i)});
    end
    for (int i = 1; i < 11; i++) begin
      if (i != 6) rdchk(regs[i], {24'h00_0000, 8'hA5 ^ 8'(i)});
    end
    foreach (regs[i]) begin
      if (regs[i] == 8'h00) begin
        // Probe addresses with no register, never the reserved range.
        wr(8'h84, 32'h0000_00FF);
        wr(8'h4C, 32'h0000_00FF);
        rdchk(8'h84, 32'h0);
        rdchk(8'h4C, 32'h0);
        rdchk(8'h04, 32'hA4);
      end
    end
    wr(8'h04, 32'h0F);
    wr(8'h00, 32'h55);
    wr(8'h08, 32'h33);
    wr(8'h28, 32'h5A);
    wr(8'h2C, 32'hFF);
    wr(8'h38, 32'hFF);
    i_pg_alt_out <= 8'hC6;
    i_pg_alt_drive <= 8'h96;
    wait6();
    e = g_drive(8'h55, 8'h0F, 8'h33, 8'h5A, 8'hC6, 8'h96);
    en = ~e[15:8];
    pin = (e[7:0] & en) | ~en;
    check("pg_oe_n", o_pg_oe_n, e[15:8]);
    check("pg_out", o_pg_out & en, e[7:0] & en);
    check("pg_alt_in", o_pg_alt_in, pin & 8'h33);
    check("pg_pu_ie", {o_pg_pullup, o_pg_in_en}, 16'hFFFF);
    check("external_interrupt_4", o_external_interrupt_4, pin[3]);
    rdchk(8'h00, (8'h0F & 8'h55) | (8'hF0 & pin));
    wr(8'h00, 32'h5D);
    wait6();
    check("external_interrupt_4_high", o_external_interrupt_4, 1'b1);
    wr(8'h38, 32'hF7);
    wait6();
    check("external_interrupt_4_off", o_external_interrupt_4, 1'b0);
    wr(8'h08, 32'h3B);
    wr(8'h38, 32'hFF);
    wait6();
    check("external_interrupt_4_alt", o_external_interrupt_4, 1'b1);
    wr(8'h44, 32'hF0);
    wr(8'h40, 32'hA5);
    wr(8'h48, 32'h30);
    wr(8'h6C, 32'hFF);
    wr(8'h78, 32'hFF);
    wait6();
    check("ph_oe_n", o_ph_oe_n, 8'h3F);
    check("ph_out", o_ph_out & 8'hC0, 8'h80);
    check("ph_timer", o_ph_timer_in, 8'h30);
    check("ph_pu_ie", {o_ph_pullup, o_ph_in_en}, 16'hFFFF);
    rdchk(8'h40, 32'hAF);
    wr(8'h04, 32'hFF);
    wr(8'h00, 32'h3C);
    rdchk(8'h00, 32'h3C);
    wr(8'h08, 32'h80);
    wait6();
    check("pg_timer_out", {o_pg_oe_n[7], o_pg_out[7]}, 2'b01);
    do_reset(1'b1);
    results();
  end
endmodule
